// ### rtl/pfm_port_f.sv
// port F: registers, AXI4-Lite slave, standby handling and pin drivers
module pfm_port_f
  import pfm_pkg::*;
(
  input  wire logic          REF_CLK_I,
  input  wire logic          RESET_I,
  input  wire logic          CE_I,
  input  wire logic [2:0]    MODE_I,
  input  wire logic          HW_STANDBY_I,
  input  wire logic          SW_STANDBY_I,
  input  wire logic          MANUAL_RESET_I,
  input  wire logic          SYS_CLOCK_I,
  input  wire logic          ADDR_STROBE_N_I,
  input  wire logic          READ_STROBE_N_I,
  input  wire logic          HIGH_BYTE_WRITE_STROBE_N_I,
  input  wire logic          LOW_BYTE_WRITE_STROBE_N_I,
  input  wire logic          BUS_REQUEST_OUT_N_I,
  input  wire logic          BUS_ACK_OUT_N_I,
  output logic               STALL_N_O,
  output logic               BUS_REQUEST_IN_N_O,
  input  wire logic [7:0]    PF_IN_I,
  output logic      [7:0]    PF_OUT_O,
  output logic      [7:0]    PF_OE_N_O,
  input  wire logic [AW-1:0] S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output logic               S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output logic               S_AXI_WREADY,
  output logic [1:0]         S_AXI_BRESP,
  output logic               S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  input  wire logic [AW-1:0] S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output logic               S_AXI_ARREADY,
  output logic [31:0]        S_AXI_RDATA,
  output logic [1:0]         S_AXI_RRESP,
  output logic               S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin inputs

  logic [7:0] pin_s;
  logic [2:0] mode_s;
  logic       hw_s;
  logic       sw_s;
  logic       mrst_s;

  pfm_sync #(
    .W (14)
  ) u_sync (
    .clk_i (REF_CLK_I),
    .ce_i  (CE_I),
    .d_i   ({PF_IN_I, MODE_I, HW_STANDBY_I, SW_STANDBY_I, MANUAL_RESET_I}),
    .q_o   ({pin_s, mode_s, hw_s, sw_s, mrst_s})
  );

  logic init;
  logic bus_mode;

  // power-on reset and hardware standby initialise; manual reset does not
  assign init     = RESET_I | hw_s;
  assign bus_mode = is_bus_mode(mode_s);

  ////////////////////////////////////////////////////////////////////////////
  // register bus: write path

  logic            aw_have_q;
  logic            w_have_q;
  logic [AW-1:0]   awaddr_q;
  logic [7:0]      wdata_q;
  logic            wlane_q;
  logic            bvalid_q;
  logic [1:0]      bresp_q;
  logic            wr_fire;
  pfm_reg_e        wr_reg;
  logic            wr_ok;

  assign S_AXI_AWREADY = CE_I & ~aw_have_q;
  assign S_AXI_WREADY  = CE_I & ~w_have_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;

  assign wr_fire = CE_I & aw_have_q & w_have_q & ~bvalid_q;
  assign wr_reg  = reg_of(awaddr_q);
  // a write without lane 0 is answered but stores nothing
  assign wr_ok   = wr_fire & wlane_q;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (CE_I)
    begin
      if (S_AXI_AWVALID && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      else if (wr_fire)
      begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= 8'h00;
      wlane_q  <= 1'b0;
    end
    else if (CE_I)
    begin
      if (S_AXI_WVALID && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA[7:0];
        wlane_q  <= S_AXI_WSTRB[0];
      end
      else if (wr_fire)
      begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (S_AXI_BREADY)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port registers

  logic [7:0] dir_q;
  logic [7:0] lat_q;
  logic [7:0] sbc_q;
  logic [7:0] bcl_q;
  logic [7:0] rb_q;

  // direction: whole-byte writes only, the value cannot be read back
  always_ff @(posedge REF_CLK_I)
  begin
    if (init)
      dir_q <= dir_init(mode_s);
    else if (wr_ok && wr_reg == REG_DIR)
      dir_q <= wdata_q;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (init)
      lat_q <= LAT_RST;
    else if (wr_ok && wr_reg == REG_LAT)
      lat_q <= wdata_q;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (init)
    begin
      sbc_q <= SBC_RST;
      bcl_q <= BCL_RST;
    end
    else if (wr_ok && wr_reg == REG_SBC)
      sbc_q <= wdata_q;
    else if (wr_ok && wr_reg == REG_BCL)
      bcl_q <= wdata_q;
  end

  // readback is not writable; it samples continuously except when frozen
  always_ff @(posedge REF_CLK_I)
  begin
    if (init)
      rb_q <= pin_s;
    else if (CE_I && !(mrst_s || sw_s))
      rb_q <= rb_mix(dir_q, lat_q, pin_s);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus: read path

  logic        rvalid_q;
  logic [7:0]  rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_val;
  logic [1:0]  rd_resp;

  assign S_AXI_ARREADY = CE_I & ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = {24'h000000, rdata_q};
  assign S_AXI_RRESP   = rresp_q;

  always_comb
  begin
    rd_val  = 8'h00;
    rd_resp = RESP_OKAY;
    case (reg_of(S_AXI_ARADDR))
      REG_DIR: rd_val = 8'h00;
      REG_RB:  rd_val = rb_q;
      REG_LAT: rd_val = lat_q;
      REG_SBC: rd_val = sbc_q;
      REG_BCL: rd_val = bcl_q;
      default: rd_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      rresp_q  <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (S_AXI_ARVALID && !rvalid_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_resp;
      end
      else if (S_AXI_RREADY)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function selection and drivers

  logic [7:0] mux_val;
  logic [7:0] mux_drv;
  logic [7:0] bus_out;
  logic [7:0] sby_mask;
  logic       hold;
  logic [7:0] out_q;
  logic [7:0] oe_n_q;
  logic [7:0] out_d;
  logic [7:0] oe_n_d;

  pfm_pin_mux u_mux (
    .bus_mode_i               (bus_mode),
    .dir_i                    (dir_q),
    .latch_i                  (lat_q),
    .pin_i                    (pin_s),
    .sys_clock_i              (SYS_CLOCK_I),
    .address_strobe_i         (ADDR_STROBE_N_I),
    .read_strobe_i            (READ_STROBE_N_I),
    .high_byte_write_strobe_i (HIGH_BYTE_WRITE_STROBE_N_I),
    .low_byte_write_strobe_i  (LOW_BYTE_WRITE_STROBE_N_I),
    .bus_request_out_i        (BUS_REQUEST_OUT_N_I),
    .bus_ack_out_i            (BUS_ACK_OUT_N_I),
    .request_out_enable_i     (bcl_q[REQOE_BIT]),
    .stall_enable_i           (bcl_q[STALL_BIT]),
    .bus_release_enable_i     (bcl_q[BUS_RELEASE_ENABLE_BIT]),
    .pin_val_o                (mux_val),
    .pin_drv_o                (mux_drv),
    .bus_out_o                (bus_out),
    .stall_n_o                (STALL_N_O),
    .bus_request_in_n_o       (BUS_REQUEST_IN_N_O)
  );

  assign hold     = sbc_q[HOLD_BIT];
  assign sby_mask = sw_s ? bus_out : 8'h00;

  // only bus control outputs are affected by software standby
  always_comb
  begin
    if (hold)
    begin
      out_d  = (mux_val & ~sby_mask) | (out_q & sby_mask);
      oe_n_d = (~mux_drv & ~sby_mask) | (oe_n_q & sby_mask);
    end
    else
    begin
      out_d  = mux_val;
      oe_n_d = ~mux_drv | sby_mask;
    end
  end

  // registered drivers cost one cycle of strobe delay but keep pins glitch free
  always_ff @(posedge REF_CLK_I)
  begin
    if (init)
    begin
      out_q  <= 8'h00;
      oe_n_q <= 8'hff;
    end
    else if (CE_I)
    begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign PF_OUT_O  = out_q;
  assign PF_OE_N_O = oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic act;

  assign act = CE_I & ~hw_s & ~sw_s;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  a_dir_reset_val: assert property ($fell(RESET_I) |-> dir_q == dir_init(mode_s))
    else $error("direction reset value wrong");

  a_dir_read_zero: assert property (S_AXI_ARVALID && S_AXI_ARREADY
      && reg_of(S_AXI_ARADDR) == REG_DIR |=> S_AXI_RVALID && S_AXI_RDATA == 32'h0)
    else $error("direction read not zero");

  a_dir_kept: assert property (CE_I && !hw_s && !(wr_ok && wr_reg == REG_DIR)
      |=> $stable(dir_q))
    else $error("direction changed without write");

  a_clk_pin: assert property (act && dir_q[PIN_CLK]
      |=> !PF_OE_N_O[PIN_CLK] && PF_OUT_O[PIN_CLK] == $past(SYS_CLOCK_I))
    else $error("clock pin not driven");

  a_bus_strobes: assert property (act && bus_mode
      |=> PF_OE_N_O[PIN_AS:PIN_LWR] == 4'h0
          && PF_OUT_O[PIN_RD] == $past(READ_STROBE_N_I))
    else $error("strobe pins not driven");

  a_single_chip: assert property (act && !bus_mode
      |=> PF_OE_N_O[6:0] == ~$past(dir_q[6:0]))
    else $error("port direction wrong");

  a_gen_low_pins: assert property (act && bus_mode && bcl_q == 8'h00
      |=> PF_OE_N_O[2:0] == ~$past(dir_q[2:0]))
    else $error("low pins direction wrong");

  a_req_out: assert property (act && bus_mode && bcl_q[REQOE_BIT]
      |=> !PF_OE_N_O[PIN_REQ] && PF_OUT_O[PIN_REQ] == $past(BUS_REQUEST_OUT_N_I))
    else $error("request pin not driven");

  a_release_pins: assert property (act && bus_mode && bcl_q[BUS_RELEASE_ENABLE_BIT]
      |=> PF_OE_N_O[PIN_BUS_REQUEST_IN] && !PF_OE_N_O[PIN_ACK])
    else $error("release pins wrong");

  a_readback_mix: assert property (CE_I && !hw_s && !sw_s && !mrst_s
      |=> rb_q == rb_mix($past(dir_q), $past(lat_q), $past(pin_s)))
    else $error("readback value wrong");

  a_readback_hold: assert property (CE_I && !hw_s && (sw_s || mrst_s) |=> $stable(rb_q))
    else $error("readback not held");

  a_standby_float: assert property (CE_I && sw_s && !hw_s && !hold
      |=> (PF_OE_N_O & $past(bus_out)) == $past(bus_out))
    else $error("bus outputs not floated");

  a_standby_hold: assert property (CE_I && sw_s && !hw_s && hold
      |=> ((PF_OUT_O ^ $past(PF_OUT_O)) & $past(bus_out)) == 8'h00)
    else $error("bus outputs not held");

endmodule

// ### rtl/pfm_pkg.sv
// constants, register map and helpers for the port F pin/bus multiplexer
//
// Contract
// - direction register is write-only, eight bits
// - power-on/hw standby loads direction 80 or 00
// - manual reset, sw standby keep direction, latch
// - sw standby holds or floats bus outputs
// - pin 7 drives system clock when bit set
// - bus modes force pins 6-3 to strobes
// - bus modes: pins 2-0 follow direction bits when BCL is zero
// - single-chip modes: pins 6-0 follow direction
// - output latch read/write, resets to zero
// - readback register is read-only, writes ignored
// - readback gives latch if output, else pin
// - readback tracks pins, holds in sw standby/manual reset
// - pin 2 request out, else wait in, else port
// - release enable: pin 1 ack out, pin 0 request in
package pfm_pkg;

  localparam int unsigned AW = 18;

  // printed offsets are register indices; byte address is index times four
  localparam logic [15:0] DIR_IDX = 16'hfebe;
  localparam logic [15:0] RB_IDX  = 16'hff5e;
  localparam logic [15:0] LAT_IDX = 16'hff6e;
  localparam logic [15:0] SBC_IDX = 16'hff3a;
  localparam logic [15:0] BCL_IDX = 16'hfed5;

  localparam logic [7:0] DIR_RST_BUS = 8'h80;
  localparam logic [7:0] DIR_RST_SC  = 8'h00;
  localparam logic [7:0] LAT_RST     = 8'h00;
  localparam logic [7:0] SBC_RST     = 8'h00;
  localparam logic [7:0] BCL_RST     = 8'h00;

  localparam int unsigned HOLD_BIT  = 3;
  localparam int unsigned STALL_BIT = 0;
  localparam int unsigned REQOE_BIT = 6;
  localparam int unsigned BUS_RELEASE_ENABLE_BIT  = 7;

  localparam int unsigned PIN_CLK  = 7;
  localparam int unsigned PIN_AS   = 6;
  localparam int unsigned PIN_RD   = 5;
  localparam int unsigned PIN_HWR  = 4;
  localparam int unsigned PIN_LWR  = 3;
  localparam int unsigned PIN_REQ  = 2;
  localparam int unsigned PIN_ACK  = 1;
  localparam int unsigned PIN_BUS_REQUEST_IN = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_DIR  = 3'h1,
    REG_RB   = 3'h2,
    REG_LAT  = 3'h3,
    REG_SBC  = 3'h4,
    REG_BCL  = 3'h5
  } pfm_reg_e;

  function automatic logic is_bus_mode(input logic [2:0] m);
    return (m == 3'h1) || (m == 3'h2) || (m == 3'h4) || (m == 3'h5) || (m == 3'h6);
  endfunction

  function automatic logic [7:0] dir_init(input logic [2:0] m);
    return is_bus_mode(m) ? DIR_RST_BUS : DIR_RST_SC;
  endfunction

  function automatic logic [7:0] rb_mix(input logic [7:0] dir, input logic [7:0] lat,
                                        input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction

  function automatic pfm_reg_e reg_of(input logic [AW-1:0] a);
    logic [15:0] idx;
    idx = a[AW-1:2];
    if (idx == DIR_IDX) return REG_DIR;
    else if (idx == RB_IDX) return REG_RB;
    else if (idx == LAT_IDX) return REG_LAT;
    else if (idx == SBC_IDX) return REG_SBC;
    else if (idx == BCL_IDX) return REG_BCL;
    else return REG_NONE;
  endfunction

endpackage

// ### rtl/pfm_sync.sv
// two-stage synchroniser for pin-level inputs
module pfm_sync
  import pfm_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // no reset: pins settle within two edges while reset is held
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// ### rtl/pfm_pin_mux.sv
// pin function selection for port F
module pfm_pin_mux
  import pfm_pkg::*;
(
  input  wire logic       bus_mode_i,
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] latch_i,
  input  wire logic [7:0] pin_i,
  input  wire logic       sys_clock_i,
  input  wire logic       address_strobe_i,
  input  wire logic       read_strobe_i,
  input  wire logic       high_byte_write_strobe_i,
  input  wire logic       low_byte_write_strobe_i,
  input  wire logic       bus_request_out_i,
  input  wire logic       bus_ack_out_i,
  input  wire logic       request_out_enable_i,
  input  wire logic       stall_enable_i,
  input  wire logic       bus_release_enable_i,
  output logic      [7:0] pin_val_o,
  output logic      [7:0] pin_drv_o,
  output logic      [7:0] bus_out_o,
  output logic            stall_n_o,
  output logic            bus_request_in_n_o
);

  always_comb
  begin
    pin_val_o = latch_i;
    pin_drv_o = dir_i;
    bus_out_o = 8'h00;
    stall_n_o = 1'b1;
    bus_request_in_n_o = 1'b1;
    pin_val_o[PIN_CLK] = sys_clock_i;
    if (bus_mode_i)
    begin
      pin_val_o[PIN_AS]  = address_strobe_i;
      pin_val_o[PIN_RD]  = read_strobe_i;
      pin_val_o[PIN_HWR] = high_byte_write_strobe_i;
      pin_val_o[PIN_LWR] = low_byte_write_strobe_i;
      pin_drv_o[PIN_AS:PIN_LWR] = 4'hf;
      bus_out_o[PIN_AS:PIN_LWR] = 4'hf;
      if (request_out_enable_i)
      begin
        pin_val_o[PIN_REQ] = bus_request_out_i;
        pin_drv_o[PIN_REQ] = 1'b1;
        bus_out_o[PIN_REQ] = 1'b1;
      end
      else if (stall_enable_i)
      begin
        pin_drv_o[PIN_REQ] = 1'b0;
        stall_n_o = pin_i[PIN_REQ];
      end
      if (bus_release_enable_i)
      begin
        pin_val_o[PIN_ACK] = bus_ack_out_i;
        pin_drv_o[PIN_ACK] = 1'b1;
        bus_out_o[PIN_ACK] = 1'b1;
        pin_drv_o[PIN_BUS_REQUEST_IN] = 1'b0;
        bus_request_in_n_o = pin_i[PIN_BUS_REQUEST_IN];
      end
    end
  end

endmodule

// ### dv/pfm_pins_model.sv
// behavioural model of the parts hanging on the port F pins
module pfm_pins_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] pf_out_i,
  input  wire logic [7:0] pf_oe_n_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h00;
  // no pull on these pins: a floating pin wanders, so stale levels never pass
  always_ff @(posedge clk_i)
  begin
    float_q <= ~pin_o;
  end
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!pf_oe_n_i[i]) pin_o[i] = pf_out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else pin_o[i] = float_q[i];
    end
  end
endmodule

// ### dv/tb.sv
// self-checking bench for the port F pin multiplexer
module tb
  import pfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk, rst, hws, sws, mrs, sclk, bro, bak, stall_n, bus_request_in_n, bus, ce;
  logic [3:0]    stb, strb;
  logic [2:0]    mode, m;
  logic [7:0]    ext_en, ext_val, pin, pf_out, pf_oe_n, dir, lat, bcl, oe, out, ev, w, rb;
  logic [AW-1:0] awaddr, araddr;
  logic          awv, wv, bry, arv, rry, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic [31:0]   wdata, rdata, d;
  logic [1:0]    bresp, rresp, r;
  logic [6:0]    rs;
  int            n_errors, n_checks, seed;
  ////////////////////////////////////////////////////////////////////////////
  pfm_port_f u_pfm_port_f (.REF_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .MODE_I(mode),
    .HW_STANDBY_I(hws), .SW_STANDBY_I(sws), .MANUAL_RESET_I(mrs), .SYS_CLOCK_I(sclk),
    .ADDR_STROBE_N_I(stb[3]), .READ_STROBE_N_I(stb[2]), .HIGH_BYTE_WRITE_STROBE_N_I(stb[1]),
    .LOW_BYTE_WRITE_STROBE_N_I(stb[0]), .BUS_REQUEST_OUT_N_I(bro), .BUS_ACK_OUT_N_I(bak),
    .STALL_N_O(stall_n), .BUS_REQUEST_IN_N_O(bus_request_in_n), .PF_IN_I(pin), .PF_OUT_O(pf_out),
    .PF_OE_N_O(pf_oe_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bry), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rry));
  pfm_pins_model u_pfm_pins_model (.clk_i(clk), .pf_out_i(pf_out), .pf_oe_n_i(pf_oe_n),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 200)
    begin
      n_errors++;
      $display("Error t=%0t bus answer missing", $time);
      report_and_stop();
    end
  endtask
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] v, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      tick(n);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    bry <= 1'b0;
    chk_v(bresp, er);
  endtask
  task automatic axi_rd(input logic [15:0] idx);
    int n = 0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      tick(n);
      if (arv && arrdy) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rry <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    axi_rd(idx);
    chk_v(d, {24'h0, exp});
    chk_v(r, RESP_OKAY);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic do_reset(input logic [2:0] md);
    @(posedge clk);
    rst <= 1'b1;
    mode <= md;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic f_bus(input logic [2:0] md);
    return md inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  endfunction
  function automatic logic [7:0] f_oe(input logic b, input logic [7:0] dr, input logic [7:0] bc);
    logic [7:0] o;
    o = ~dr;
    if (b)
    begin
      o[6:3] = 4'h0;
      if (bc[6]) o[2] = 1'b0;
      else if (bc[0]) o[2] = 1'b1;
      if (bc[7]) o[1:0] = 2'b01;
    end
    return o;
  endfunction
  function automatic logic [7:0] f_out(input logic b, input logic [7:0] lt, input logic [7:0] bc,
                                       input logic [6:0] s);
    logic [7:0] o;
    o = lt;
    o[7] = s[6];
    if (b)
    begin
      o[6:3] = s[3:0];
      if (bc[6]) o[2] = s[5];
      if (bc[7]) o[1] = s[4];
    end
    return o;
  endfunction
  // stimulus the pins see and what the readback should give back
  task automatic apply_and_expect();
    oe = f_oe(bus, dir, bcl);
    out = f_out(bus, lat, bcl, rs);
    {sclk, bro, bak, stb} <= rs;
    ext_val <= ev;
    ext_en <= oe;
    settle();
    w = (out & ~oe) | (ev & oe);
    rb = (dir & lat) | (~dir & w);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, hws, sws, mrs, awv, wv, bry, arv, rry} = 9'h100;
    {sclk, bro, bak, stb, ext_en, ext_val, awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    strb = 4'hf;
    mode = 3'h1;
    seed = 3271;
    n_errors = 0;
    n_checks = 0;
    for (int i = 0; i < 8; i++)
    begin
      m = 3'(i);
      bus = f_bus(m);
      do_reset(m);
      chk_v(pf_oe_n, f_oe(bus, bus ? 8'h80 : 8'h00, 8'h00));
      rd_chk(LAT_IDX, 8'h00);
      for (int k = 0; k < 5; k++)
      begin
        dir = 8'($random(seed));
        lat = 8'($random(seed));
        bcl = 8'($random(seed)) & 8'hc1;
        rs = 7'($random(seed));
        ev = 8'($random(seed));
        axi_wr(DIR_IDX, dir, RESP_OKAY);
        axi_wr(LAT_IDX, lat, RESP_OKAY);
        axi_wr(BCL_IDX, bcl, RESP_OKAY);
        apply_and_expect();
        chk_v(pf_oe_n, oe);
        chk_v(pf_out & ~oe, out & ~oe);
        chk_b(stall_n, (bus && !bcl[6] && bcl[0]) ? w[2] : 1'b1);
        chk_b(bus_request_in_n, (bus && bcl[7]) ? w[0] : 1'b1);
        rd_chk(RB_IDX, rb);
        axi_wr(RB_IDX, ~rb, RESP_OKAY);
        rd_chk(RB_IDX, rb);
        rd_chk(DIR_IDX, 8'h00);
        rd_chk(LAT_IDX, lat);
      end
    end
    // corner cases in a bus mode: unmapped place, standby, manual and hw reset
    do_reset(3'h1);
    bus = f_bus(3'h1);
    axi_rd(16'h0000);
    chk_v(d, 32'h0);
    chk_v(r, RESP_SLVERR);
    axi_wr(16'h0001, 8'h5a, RESP_SLVERR);
    // a write without lane 0 must leave the latch alone
    strb <= 4'h0;
    axi_wr(LAT_IDX, 8'hff, RESP_OKAY);
    strb <= 4'hf;
    rd_chk(LAT_IDX, 8'h00);
    {dir, lat, bcl, rs, ev} = {8'h07, 8'ha5, 8'h00, 7'h0a, 8'h3c};
    axi_wr(DIR_IDX, dir, RESP_OKAY);
    axi_wr(LAT_IDX, lat, RESP_OKAY);
    axi_wr(SBC_IDX, 8'h08, RESP_OKAY);
    apply_and_expect();
    sws <= 1'b1;
    settle();
    stb <= 4'h5;
    ext_val <= ~ev;
    settle();
    chk_v(pf_out[6:3], 4'ha);
    chk_v(pf_oe_n, oe);
    rd_chk(RB_IDX, rb);
    sws <= 1'b0;
    settle();
    axi_wr(SBC_IDX, 8'h00, RESP_OKAY);
    sws <= 1'b1;
    settle();
    chk_v(pf_oe_n, oe | 8'h78);
    sws <= 1'b0;
    ev = ~ev;
    apply_and_expect();
    chk_v(pf_oe_n, oe);
    rd_chk(LAT_IDX, lat);
    // clock enable low: strobe pins must not follow their inputs
    ce <= 1'b0;
    stb <= ~stb;
    settle();
    chk_v(pf_out & ~oe, out & ~oe);
    ce <= 1'b1;
    stb <= rs[3:0];
    settle();
    mrs <= 1'b1;
    ext_val <= ~ev;
    settle();
    rd_chk(RB_IDX, rb);
    rd_chk(LAT_IDX, lat);
    chk_v(pf_oe_n, oe);
    mrs <= 1'b0;
    hws <= 1'b1;
    settle();
    chk_v(pf_oe_n, 8'hff);
    hws <= 1'b0;
    settle();
    rd_chk(LAT_IDX, 8'h00);
    chk_v(pf_oe_n & 8'hf8, 8'h00);
    report_and_stop();
  end
endmodule
